// [rtl/pca_mode_counter.v]
`include "pca_consts.vh"

// Operation
// - With pulse mode on, wide pulse select picks 16-bit PWM at 1, 8 to 11-bit at 0.
// - Compare enable at 1 turns on the module comparator against the counter.
// - Rising capture enable at 1 captures on positive input edges.
// - Falling capture enable at 1 captures on negative input edges.
// - Match flag enable at 1 sets the module flag on every counter match.
// - Toggle enable at 1 inverts the output pin on every counter match.
// - Toggle and pulse mode both at 1 give frequency output mode.
// - Pulse mode at 1 with toggle at 0 and compare enable at 1 drives PWM on the output pin, width chosen by wide pulse select.
// - Flag interrupt enable gates the module flag onto its interrupt request.
// - While the watchdog is enabled, writes to module 5 mode are ignored.
// - The counter low register reads and writes counter bits 7:0, reset zero.
// - While the watchdog is enabled, counter low writes have no effect.
// - Reading counter low snapshots the high byte; high reads return the snapshot.
// - A write to a compare low byte clears that module's compare enable.
// - The shared cycle length field picks 8, 9, 10 or 11 bit short PWM.
module pca_mode_counter (
  input wire clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  input wire count_tick,
  input wire watchdog_enable_bit,
  input wire [5:0] flag_clear,
  input wire [5:0] capture_pin,
  output reg [5:0] capture_compare_flag_q,
  output reg [5:0] flag_request_q,
  output reg [5:0] module_output_pin_q,
  output reg watchdog_match_q
);

  reg [15:0] counter_q;
  reg counter_moved_q;
  reg [7:0] snapshot_q;
  reg [1:0] cycle_length_field_q;
  reg [7:0] mode_q [0:5];
  reg [15:0] cmp_q [0:5];
  wire [5:0] cap_hit;
  wire [5:0] match_hit;
  wire [5:0] pin_raw;
  wire [2:0] mode_ch;
  wire [2:0] cmpl_ch;
  wire [2:0] cmph_ch;
  wire counter_low_wr;
  wire counter_high_wr;
  reg [5:0] flag_d;
  integer i;
  integer j;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function [2:0] mode_index;
    input [7:0] a;
    begin
      case (a)
        `ADDR_MODE0: mode_index = 3'h0;
        `ADDR_MODE1: mode_index = 3'h1;
        `ADDR_MODE2: mode_index = 3'h2;
        `ADDR_MODE3: mode_index = 3'h3;
        `ADDR_MODE4: mode_index = 3'h4;
        `ADDR_MODE5: mode_index = 3'h5;
        default: mode_index = `NO_CHANNEL;
      endcase
    end
  endfunction

  function [2:0] cmpl_index;
    input [7:0] a;
    begin
      case (a)
        `ADDR_CMPL0: cmpl_index = 3'h0;
        `ADDR_CMPL1: cmpl_index = 3'h1;
        `ADDR_CMPL2: cmpl_index = 3'h2;
        `ADDR_CMPL3: cmpl_index = 3'h3;
        `ADDR_CMPL4: cmpl_index = 3'h4;
        `ADDR_CMPL5: cmpl_index = 3'h5;
        default: cmpl_index = `NO_CHANNEL;
      endcase
    end
  endfunction

  function [2:0] cmph_index;
    input [7:0] a;
    begin
      case (a)
        `ADDR_CMPH0: cmph_index = 3'h0;
        `ADDR_CMPH1: cmph_index = 3'h1;
        `ADDR_CMPH2: cmph_index = 3'h2;
        `ADDR_CMPH3: cmph_index = 3'h3;
        `ADDR_CMPH4: cmph_index = 3'h4;
        `ADDR_CMPH5: cmph_index = 3'h5;
        default: cmph_index = `NO_CHANNEL;
      endcase
    end
  endfunction

  assign mode_ch = mode_index(sfr_addr);
  assign cmpl_ch = cmpl_index(sfr_addr);
  assign cmph_ch = cmph_index(sfr_addr);
  assign counter_low_wr = sfr_wr && (sfr_addr == `ADDR_COUNTER_LOW) && !watchdog_enable_bit;
  assign counter_high_wr = sfr_wr && (sfr_addr == `ADDR_COUNTER_HIGH) && !watchdog_enable_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Shared counter and high byte snapshot
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counter_q <= `RESET_WORD;
      counter_moved_q <= 1'b0;
      snapshot_q <= `RESET_BYTE;
      cycle_length_field_q <= `RESET_CYCLE;
    end
    else
    begin
      counter_moved_q <= count_tick && !counter_low_wr && !counter_high_wr;
      if (counter_low_wr)
      begin
        counter_q[7:0] <= sfr_wdata;
      end
      else if (counter_high_wr)
      begin
        counter_q[15:8] <= sfr_wdata;
      end
      else if (count_tick)
      begin
        counter_q <= counter_q + 16'h0001;
      end
      if (sfr_rd && sfr_addr == `ADDR_COUNTER_LOW)
      begin
        snapshot_q <= counter_q[15:8];
      end
      if (sfr_wr && sfr_addr == `ADDR_CYCLE_CFG)
      begin
        cycle_length_field_q <= sfr_wdata[`CYCLE_LEN_MSB:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and compare registers, flags and requests
  always @*
  begin
    flag_d = capture_compare_flag_q & ~flag_clear;
    for (i = 0; i < `NUM_MODULES; i = i + 1)
    begin
      if (cap_hit[i] || match_hit[i])
      begin
        flag_d[i] = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (j = 0; j < `NUM_MODULES; j = j + 1)
      begin
        mode_q[j] <= `RESET_BYTE;
        cmp_q[j] <= `RESET_WORD;
      end
      capture_compare_flag_q <= 6'h00;
      flag_request_q <= 6'h00;
      module_output_pin_q <= 6'h00;
      watchdog_match_q <= 1'b0;
    end
    else
    begin
      capture_compare_flag_q <= flag_d;
      module_output_pin_q <= pin_raw;
      watchdog_match_q <= watchdog_enable_bit && counter_moved_q
        && (counter_q == cmp_q[`WDT_MODULE]);
      for (j = 0; j < `NUM_MODULES; j = j + 1)
      begin
        flag_request_q[j] <= flag_d[j] && mode_q[j][`BIT_FLAG_IRQ];
        if (cap_hit[j])
        begin
          cmp_q[j] <= counter_q;
        end
        else if (sfr_wr && cmpl_ch == j)
        begin
          cmp_q[j][7:0] <= sfr_wdata;
        end
        else if (sfr_wr && cmph_ch == j)
        begin
          cmp_q[j][15:8] <= sfr_wdata;
        end
        if (sfr_wr && cmpl_ch == j)
        begin
          mode_q[j][`BIT_COMPARE_EN] <= 1'b0;
        end
        else if (sfr_wr && mode_ch == j)
        begin
          if (!(j == `WDT_MODULE && watchdog_enable_bit))
          begin
            mode_q[j] <= sfr_wdata;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sfr_rdata_q <= `RESET_BYTE;
    end
    else if (sfr_rd)
    begin
      if (sfr_addr == `ADDR_COUNTER_LOW)
      begin
        sfr_rdata_q <= counter_q[7:0];
      end
      else if (sfr_addr == `ADDR_COUNTER_HIGH)
      begin
        sfr_rdata_q <= snapshot_q;
      end
      else if (sfr_addr == `ADDR_CYCLE_CFG)
      begin
        sfr_rdata_q <= {6'h00, cycle_length_field_q};
      end
      else if (mode_ch != `NO_CHANNEL)
      begin
        sfr_rdata_q <= mode_q[mode_ch];
      end
      else if (cmpl_ch != `NO_CHANNEL)
      begin
        sfr_rdata_q <= cmp_q[cmpl_ch][7:0];
      end
      else if (cmph_ch != `NO_CHANNEL)
      begin
        sfr_rdata_q <= cmp_q[cmph_ch][15:8];
      end
      else
      begin
        sfr_rdata_q <= `RESET_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture/compare channels
  genvar g;
  generate
    for (g = 0; g < `NUM_MODULES; g = g + 1)
    begin : chan
      capture_module u_mod (
        .clk(clk),
        .rst_n(rst_n),
        .mode(mode_q[g]),
        .cycle_length_field(cycle_length_field_q),
        .counter(counter_q),
        .counter_moved(counter_moved_q),
        .cmp_value(cmp_q[g]),
        .capture_pin(capture_pin[g]),
        .capture_hit_q(cap_hit[g]),
        .match_hit_q(match_hit[g]),
        .module_output_pin_q(pin_raw[g])
      );
    end
  endgenerate

endmodule // pca_mode_counter

// [rtl/pca_consts.vh]
`ifndef PCA_CONSTS_VH
`define PCA_CONSTS_VH
`define NUM_MODULES 6
`define WDT_MODULE 5
`define ADDR_COUNTER_LOW 8'hf9
`define ADDR_COUNTER_HIGH 8'hfa
`define ADDR_CYCLE_CFG 8'hdf
`define ADDR_MODE0 8'hda
`define ADDR_MODE1 8'hdb
`define ADDR_MODE2 8'hdc
`define ADDR_MODE3 8'hdd
`define ADDR_MODE4 8'hde
`define ADDR_MODE5 8'hce
`define ADDR_CMPL0 8'hfb
`define ADDR_CMPL1 8'he9
`define ADDR_CMPL2 8'heb
`define ADDR_CMPL3 8'hed
`define ADDR_CMPL4 8'hfd
`define ADDR_CMPL5 8'hd2
`define ADDR_CMPH0 8'hfc
`define ADDR_CMPH1 8'hea
`define ADDR_CMPH2 8'hec
`define ADDR_CMPH3 8'hee
`define ADDR_CMPH4 8'hfe
`define ADDR_CMPH5 8'hd3
`define BIT_WIDE_PULSE 7
`define BIT_COMPARE_EN 6
`define BIT_RISE_CAP 5
`define BIT_FALL_CAP 4
`define BIT_MATCH_FLAG 3
`define BIT_TOGGLE 2
`define BIT_PULSE_MODE 1
`define BIT_FLAG_IRQ 0
`define CYCLE_LEN_MSB 1
`define CYCLE_LEN_8 2'h0
`define CYCLE_LEN_9 2'h1
`define CYCLE_LEN_10 2'h2
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define RESET_CYCLE 2'h0
`define NO_CHANNEL 3'h7
`endif

// [rtl/capture_module.v]
`include "pca_consts.vh"

module capture_module (
  input wire clk,
  input wire rst_n,
  input wire [7:0] mode,
  input wire [1:0] cycle_length_field,
  input wire [15:0] counter,
  input wire counter_moved,
  input wire [15:0] cmp_value,
  input wire capture_pin,
  output reg capture_hit_q,
  output reg match_hit_q,
  output reg module_output_pin_q
);

  reg sync1_q;
  reg sync2_q;
  reg sync3_q;
  reg level_q;
  reg [15:0] mask;
  wire equal;
  wire steady;
  wire rise;
  wire fall;
  wire pwm_high;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser, change accepted when stages two and three agree
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      sync1_q <= capture_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (steady)
      begin
        level_q <= sync3_q;
      end
    end
  end

  assign steady = (sync2_q == sync3_q);
  assign rise = steady && sync3_q && !level_q;
  assign fall = steady && !sync3_q && level_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle length mask for the short pulse form
  always @*
  begin
    case (cycle_length_field)
      `CYCLE_LEN_8: mask = 16'h00ff;
      `CYCLE_LEN_9: mask = 16'h01ff;
      `CYCLE_LEN_10: mask = 16'h03ff;
      default: mask = 16'h07ff;
    endcase
  end

  assign equal = mode[`BIT_COMPARE_EN] && counter_moved && (counter == cmp_value);
  assign pwm_high = mode[`BIT_WIDE_PULSE] ? (counter < cmp_value)
    : ((counter & mask) < (cmp_value & mask));

  ////////////////////////////////////////////////////////////////////////////
  // Events and output pin
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_hit_q <= 1'b0;
      match_hit_q <= 1'b0;
      module_output_pin_q <= 1'b0;
    end
    else
    begin
      capture_hit_q <= (rise && mode[`BIT_RISE_CAP])
        || (fall && mode[`BIT_FALL_CAP]);
      match_hit_q <= equal && mode[`BIT_MATCH_FLAG];
      if (mode[`BIT_TOGGLE] && mode[`BIT_PULSE_MODE])
      begin
        // Frequency output: toggle on low byte match
        if (mode[`BIT_COMPARE_EN] && counter_moved && counter[7:0] == cmp_value[7:0])
        begin
          module_output_pin_q <= !module_output_pin_q;
        end
      end
      else if (mode[`BIT_PULSE_MODE])
      begin
        module_output_pin_q <= mode[`BIT_COMPARE_EN] && pwm_high;
      end
      else if (mode[`BIT_TOGGLE] && equal)
      begin
        module_output_pin_q <= !module_output_pin_q;
      end
    end
  end

endmodule // capture_module

// [verif/pca_mode_counter_sva.sv]
`include "pca_consts.vh"

module pca_mode_counter_sva (
  input logic clk,
  input logic rst_n,
  input logic [7:0] sfr_addr,
  input logic sfr_wr,
  input logic sfr_rd,
  input logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata_q,
  input logic watchdog_enable_bit,
  input logic [5:0] flag_clear,
  input logic [5:0] capture_compare_flag_q,
  input logic [5:0] flag_request_q,
  input logic [5:0] module_output_pin_q,
  input logic watchdog_match_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  rdata_hold_a: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata_q))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  cfg_unused_a: assert property (sfr_rd && sfr_addr == `ADDR_CYCLE_CFG |=> sfr_rdata_q[7:2] == 6'h00)
    else $error("cycle config upper bits not zero");
  mode_readback_a: assert property (sfr_wr && sfr_addr == `ADDR_MODE0 ##2 sfr_rd && sfr_addr == `ADDR_MODE0
    |=> sfr_rdata_q == $past(sfr_wdata, 3))
    else $error("mode readback differs from write");
  req_needs_flag_a: assert property ((flag_request_q & ~capture_compare_flag_q) == 6'h00)
    else $error("request without flag");
  flag_sticky_a: assert property ((~capture_compare_flag_q & $past(capture_compare_flag_q)
    & ~$past(flag_clear)) == 6'h00)
    else $error("flag dropped without clear");
  wdt_pulse_a: assert property (watchdog_match_q |=> !watchdog_match_q)
    else $error("watchdog match longer than one cycle");
  wdt_off_quiet_a: assert property (!watchdog_enable_bit [*4] |-> !watchdog_match_q)
    else $error("watchdog match while watchdog off");
  ////////////////////////////////////////////////////////////////////////////////
  cover property (sfr_wr && sfr_addr == `ADDR_MODE5 && watchdog_enable_bit);
  cover property (watchdog_match_q);
  cover property ($rose(module_output_pin_q[3]));
endmodule // pca_mode_counter_sva

bind pca_mode_counter pca_mode_counter_sva u_sva (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
  .watchdog_enable_bit(watchdog_enable_bit), .flag_clear(flag_clear),
  .capture_compare_flag_q(capture_compare_flag_q), .flag_request_q(flag_request_q),
  .module_output_pin_q(module_output_pin_q), .watchdog_match_q(watchdog_match_q));

// [verif/sfr_host.sv]
module sfr_host (
  input logic clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // Data line shows the inverse once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata_q;
  endtask
endmodule // sfr_host

// [verif/tb_pca_mode_counter.sv]
`include "pca_consts.vh"
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %s exp %h got %h", what, exp, got); end end

module tb_pca_mode_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic count_tick = 1'b0;
  logic watchdog_enable_bit = 1'b0;
  logic [5:0] flag_clear = 6'h00;
  logic [5:0] capture_pin = 6'h00;
  wire [7:0] sfr_addr, sfr_wdata, sfr_rdata_q;
  wire sfr_wr, sfr_rd, watchdog_match_q;
  wire [5:0] capture_compare_flag_q, flag_request_q, module_output_pin_q;
  int n_errors = 0;
  int compares = 0;
  int wdt_pulses = 0;
  logic [7:0] rv;
  logic [7:0] modes [6] = '{`ADDR_MODE0, `ADDR_MODE1, `ADDR_MODE2, `ADDR_MODE3, `ADDR_MODE4,
    `ADDR_MODE5};
  always #4 clk = ~clk;
  // Counts watchdog match cycles, sampled where settled
  always @(negedge clk)
  begin
    if (watchdog_match_q === 1'b1)
      wdt_pulses++;
  end
  sfr_host u_host (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q));
  pca_mode_counter u_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .count_tick(count_tick),
    .watchdog_enable_bit(watchdog_enable_bit), .flag_clear(flag_clear),
    .capture_pin(capture_pin), .capture_compare_flag_q(capture_compare_flag_q),
    .flag_request_q(flag_request_q), .module_output_pin_q(module_output_pin_q),
    .watchdog_match_q(watchdog_match_q));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rv);
    `CHK(what, e, rv)
  endtask
  task automatic ticks(input int n);
    @(negedge clk);
    count_tick = 1'b1;
    repeat (n) @(negedge clk);
    count_tick = 1'b0;
  endtask
  task automatic done(input string s);
    $display("Test %s done", s);
  endtask
  task automatic conclude();
    $display("Compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100us;
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk_rd("count_low_reset", `ADDR_COUNTER_LOW, `RESET_BYTE);
    chk_rd("unmapped", 8'h00, 8'h00);
    u_host.wr(`ADDR_CYCLE_CFG, 8'hff);
    chk_rd("cycle_cfg", `ADDR_CYCLE_CFG, 8'h03);
    u_host.wr(`ADDR_CYCLE_CFG, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      chk_rd("mode_reset", modes[i], `RESET_BYTE);
      u_host.wr(modes[i], 8'ha5 ^ 8'(i));
      chk_rd("mode_rw", modes[i], 8'ha5 ^ 8'(i));
      u_host.wr(modes[i], 8'h00);
    end
    done("registers");
    // Module 0 flags with request, module 4 flags with request masked
    u_host.wr(`ADDR_CMPL0, 8'h10);
    u_host.wr(`ADDR_CMPL4, 8'h20);
    u_host.wr(`ADDR_MODE0, 8'h4d);
    u_host.wr(`ADDR_MODE4, 8'h48);
    u_host.wr(`ADDR_COUNTER_LOW, 8'h00);
    ticks(40);
    repeat (6) @(negedge clk);
    `CHK("flags", 6'h11, capture_compare_flag_q)
    `CHK("requests", 6'h01, flag_request_q)
    `CHK("pins", 6'h01, module_output_pin_q)
    u_host.wr(`ADDR_CMPL0, 8'h10);
    chk_rd("mode0_after_cmpl", `ADDR_MODE0, 8'h0d);
    flag_clear = 6'h01;
    @(negedge clk);
    flag_clear = 6'h00;
    repeat (3) @(negedge clk);
    `CHK("flags_cleared", 6'h10, capture_compare_flag_q)
    `CHK("requests_cleared", 6'h00, flag_request_q)
    done("match");
    u_host.wr(`ADDR_MODE1, 8'h20);
    u_host.wr(`ADDR_MODE2, 8'h10);
    capture_pin = 6'h06;
    repeat (8) @(negedge clk);
    `CHK("rise_capture", 6'h12, capture_compare_flag_q)
    capture_pin = 6'h00;
    repeat (8) @(negedge clk);
    `CHK("fall_capture", 6'h16, capture_compare_flag_q)
    chk_rd("captured_low", `ADDR_CMPL1, 8'h28);
    chk_rd("captured_high", `ADDR_CMPH1, 8'h00);
    done("capture");
    u_host.wr(`ADDR_CMPL3, 8'h80);
    u_host.wr(`ADDR_CMPH3, 8'h01);
    u_host.wr(`ADDR_MODE3, 8'h42);
    u_host.wr(`ADDR_COUNTER_LOW, 8'h10);
    ticks(1);
    repeat (4) @(negedge clk);
    `CHK("pwm8_high", 1'b1, module_output_pin_q[3])
    u_host.wr(`ADDR_COUNTER_LOW, 8'h90);
    ticks(1);
    repeat (4) @(negedge clk);
    `CHK("pwm8_low", 1'b0, module_output_pin_q[3])
    u_host.wr(`ADDR_MODE3, 8'hc2);
    ticks(1);
    repeat (4) @(negedge clk);
    `CHK("pwm16_high", 1'b1, module_output_pin_q[3])
    done("pwm");
    u_host.wr(`ADDR_COUNTER_HIGH, 8'h12);
    u_host.rd(`ADDR_COUNTER_LOW, rv);
    u_host.wr(`ADDR_COUNTER_HIGH, 8'h34);
    chk_rd("snapshot", `ADDR_COUNTER_HIGH, 8'h12);
    u_host.wr(`ADDR_CMPH5, 8'h34);
    u_host.wr(`ADDR_CMPL5, 8'h95);
    watchdog_enable_bit = 1'b1;
    u_host.wr(`ADDR_COUNTER_LOW, 8'h77);
    u_host.wr(`ADDR_MODE5, 8'hff);
    ticks(5);
    chk_rd("locked_low", `ADDR_COUNTER_LOW, 8'h97);
    `CHK("wdt_match", 1, wdt_pulses)
    chk_rd("locked_mode5", `ADDR_MODE5, 8'h00);
    watchdog_enable_bit = 1'b0;
    u_host.wr(`ADDR_MODE5, 8'h48);
    chk_rd("free_mode5", `ADDR_MODE5, 8'h48);
    u_host.wr(`ADDR_COUNTER_LOW, 8'h77);
    chk_rd("free_low", `ADDR_COUNTER_LOW, 8'h77);
    done("watchdog");
    // Low byte match only: plain toggle and short PWM would both leave the pin low
    u_host.wr(`ADDR_CMPL3, 8'h78);
    u_host.wr(`ADDR_MODE3, 8'h46);
    repeat (4) @(negedge clk);
    `CHK("freq_start", 1'b0, module_output_pin_q[3])
    ticks(1);
    repeat (4) @(negedge clk);
    `CHK("freq_toggle", 1'b1, module_output_pin_q[3])
    done("frequency");
    conclude();
  end
endmodule // tb_pca_mode_counter
